// ### common/fcsl_cfg.svh
// Constants for the flash command and status host controller
`ifndef FCSL_CFG_SVH
`define FCSL_CFG_SVH

// Bus shape
`define FCSL_ADDR_W 21
`define FCSL_DATA_W 16
`define FCSL_LOW_W 11

// Clock and pin timing, in ns
`define FCSL_CLK_NS 25
`define FCSL_T_ACC_NS 70
`define FCSL_T_WP_NS 40
`define FCSL_T_WH_NS 30

// Least times round up to whole cycles
`define FCSL_ACC_CYC ((`FCSL_T_ACC_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS)
`define FCSL_WP_CYC ((`FCSL_T_WP_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS)
`define FCSL_WH_CYC ((`FCSL_T_WH_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS)
`define FCSL_SYNC_CYC 4

// Command addresses in the low address field
`define FCSL_UNLOCK1 11'h555
`define FCSL_UNLOCK2 11'h2AA
`define FCSL_QUERY_ADR 11'h055

// Command codes
`define FCSL_CD_UNLOCK1 8'hAA
`define FCSL_CD_UNLOCK2 8'h55
`define FCSL_CD_IDENT 8'h90
`define FCSL_CD_PROGRAM 8'hA0
`define FCSL_CD_BYPASS 8'h20
`define FCSL_CD_ERASE 8'h80
`define FCSL_CD_CHIP 8'h10
`define FCSL_CD_SECTOR 8'h30
`define FCSL_CD_SUSPEND 8'hB0
`define FCSL_CD_RESUME 8'h30
`define FCSL_CD_QUERY 8'h98
`define FCSL_CD_RESET 8'hF0
`define FCSL_CD_BYP_EXIT 8'h00

// Status bit positions
`define FCSL_BIT_POLL 7
`define FCSL_BIT_TOGGLE1 6
`define FCSL_BIT_TLIMIT 5
`define FCSL_BIT_TOGGLE2 2

// Reset values
`define FCSL_RST_READY 1'b1

`endif

// ### common/fcsl_pkg.sv
// Types shared by the flash host controller files
`include "fcsl_cfg.svh"
package fcsl_pkg;

  typedef enum logic [3:0] {
    FCSL_OP_READ,
    FCSL_OP_RESET,
    FCSL_OP_PROGRAM,
    FCSL_OP_BYPASS_ENTER,
    FCSL_OP_BYPASS_PROGRAM,
    FCSL_OP_BYPASS_RESET,
    FCSL_OP_ERASE_CHIP,
    FCSL_OP_ERASE_SECTOR,
    FCSL_OP_SUSPEND,
    FCSL_OP_RESUME,
    FCSL_OP_ID_READ,
    FCSL_OP_PARAM_QUERY
  } fcsl_op_t;

  typedef struct packed {
    fcsl_op_t                  op;
    logic [`FCSL_ADDR_W-1:0]   addr;
    logic [`FCSL_DATA_W-1:0]   data;
  } fcsl_req_t;

  typedef struct packed {
    logic [`FCSL_DATA_W-1:0]   data;
    logic                      refused;
    logic                      timed_out;
    logic                      suspended;
  } fcsl_rsp_t;

  typedef struct packed {
    logic                      write;
    logic [`FCSL_ADDR_W-1:0]   addr;
    logic [`FCSL_DATA_W-1:0]   data;
  } fcsl_cyc_t;

  typedef enum logic [1:0] {
    FCSL_B_IDLE,
    FCSL_B_ACT,
    FCSL_B_HOLD,
    FCSL_B_GAP
  } fcsl_bus_state_t;

  typedef enum logic [3:0] {
    FCSL_S_IDLE,
    FCSL_S_ISSUE,
    FCSL_S_POLL1,
    FCSL_S_POLL2,
    FCSL_S_DECIDE,
    FCSL_S_FINAL,
    FCSL_S_RECOVER,
    FCSL_S_RESP
  } fcsl_state_t;

endpackage : fcsl_pkg

// ### logic/fcsl_bus_cycle.sv
// One asynchronous flash bus cycle, with pin input synchronisers
`timescale 1ns/100ps
`include "fcsl_cfg.svh"
module fcsl_bus_cycle #(
  parameter int AW = `FCSL_ADDR_W,
  parameter int DW = `FCSL_DATA_W
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Cycle request
  input  wire logic               start_i,
  input  fcsl_pkg::fcsl_cyc_t     cyc_i,
  output logic                    done_o,
  output logic [DW-1:0]           rdata_o,
  output logic                    ready_o,
  // Flash pins
  output logic [AW-1:0]           addr_o,
  output logic [DW-1:0]           dq_o,
  output logic                    dq_oe_o,
  input  wire logic [DW-1:0]      dq_i,
  output logic                    ce_n_o,
  output logic                    oe_n_o,
  output logic                    we_n_o,
  input  wire logic               ready_busy_n_i
);

  localparam int SW = DW + 1;
  localparam logic [SW-1:0] SYNC_RST = {`FCSL_RST_READY, {DW{1'b0}}};
  localparam logic [7:0] WR_LEN = 8'(`FCSL_WP_CYC);
  // Reads wait out the access time plus the synchroniser delay
  localparam logic [7:0] RD_LEN = 8'(`FCSL_ACC_CYC + `FCSL_SYNC_CYC);
  localparam logic [7:0] HOLD_LEN = 8'(`FCSL_WH_CYC);

  if (AW != `FCSL_ADDR_W || DW != `FCSL_DATA_W) begin : g_chk
    $error("fcsl_bus_cycle: widths must match the shared cycle type");
  end

  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] filt_q;
  wire  [SW-1:0] pins = {ready_busy_n_i, dq_i};

  // Change is taken only once the second and third stages agree
  for (genvar g = 0; g < SW; g++) begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        s1_q[g]   <= SYNC_RST[g];
        s2_q[g]   <= SYNC_RST[g];
        s3_q[g]   <= SYNC_RST[g];
        filt_q[g] <= SYNC_RST[g];
      end else begin
        s1_q[g] <= pins[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          filt_q[g] <= s3_q[g];
        end
      end
    end
  end

  fcsl_pkg::fcsl_bus_state_t state_q;
  fcsl_pkg::fcsl_cyc_t       cyc_q;
  logic [7:0]                cnt_q;
  logic [DW-1:0]             rdata_q;

  wire       in_act   = (state_q == fcsl_pkg::FCSL_B_ACT);
  wire       in_hold  = (state_q == fcsl_pkg::FCSL_B_HOLD);
  wire [7:0] act_last = (cyc_q.write ? WR_LEN : RD_LEN) - 8'h01;
  wire [7:0] hld_last = HOLD_LEN - 8'h01;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= fcsl_pkg::FCSL_B_IDLE;
      cyc_q   <= '0;
      cnt_q   <= 8'h00;
      rdata_q <= '0;
    end else begin
      unique case (state_q)
        fcsl_pkg::FCSL_B_IDLE: begin
          if (start_i) begin
            cyc_q   <= cyc_i;
            cnt_q   <= 8'h00;
            state_q <= fcsl_pkg::FCSL_B_ACT;
          end
        end
        fcsl_pkg::FCSL_B_ACT: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == act_last) begin
            cnt_q   <= 8'h00;
            state_q <= fcsl_pkg::FCSL_B_HOLD;
            if (!cyc_q.write) begin
              rdata_q <= filt_q[DW-1:0];
            end
          end
        end
        fcsl_pkg::FCSL_B_HOLD: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == hld_last) begin
            state_q <= fcsl_pkg::FCSL_B_GAP;
          end
        end
        fcsl_pkg::FCSL_B_GAP: state_q <= fcsl_pkg::FCSL_B_IDLE;
      endcase
    end
  end

  // Address and data stand through the hold so the strobe edges latch them
  assign addr_o  = cyc_q.addr;
  assign dq_o    = cyc_q.data;
  assign dq_oe_o = cyc_q.write && (in_act || in_hold);
  assign ce_n_o  = !(in_act || in_hold);
  assign we_n_o  = !(in_act && cyc_q.write);
  assign oe_n_o  = !(in_act && !cyc_q.write);
  assign done_o  = (state_q == fcsl_pkg::FCSL_B_GAP);
  assign rdata_o = rdata_q;
  assign ready_o = filt_q[DW];

endmodule : fcsl_bus_cycle

// ### logic/fcsl_host.sv
// Host controller that sequences commands and polls status of a parallel flash
`timescale 1ns/100ps
`include "fcsl_cfg.svh"
module fcsl_host #(
  parameter int AW = `FCSL_ADDR_W,
  parameter int DW = `FCSL_DATA_W
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // User requests
  input  wire logic               req_valid_i,
  output logic                    req_ready_o,
  input  fcsl_pkg::fcsl_req_t     req_i,
  // User responses and mode view
  output logic                    rsp_valid_o,
  output fcsl_pkg::fcsl_rsp_t     rsp_o,
  output logic                    bypass_o,
  output logic                    suspended_o,
  output logic                    id_mode_o,
  output logic                    flash_ready_o,
  // Flash pins
  output logic [AW-1:0]           flash_addr_o,
  output logic [DW-1:0]           flash_dq_o,
  output logic                    flash_dq_oe_o,
  input  wire logic [DW-1:0]      flash_dq_i,
  output logic                    flash_ce_n_o,
  output logic                    flash_oe_n_o,
  output logic                    flash_we_n_o,
  input  wire logic               ready_busy_n_i
);

  localparam int LW = `FCSL_LOW_W;

  if (AW != `FCSL_ADDR_W || DW != `FCSL_DATA_W || AW <= LW) begin : g_chk
    $error("fcsl_host: widths must match the shared request type");
  end

  function automatic fcsl_pkg::fcsl_cyc_t wr(input logic [AW-1:0] a, input logic [7:0] d);
    fcsl_pkg::fcsl_cyc_t c;
    c = '{write: 1'b1, addr: a, data: {{(DW-8){1'b0}}, d}};
    return c;
  endfunction : wr

  // Command cycle i of request r; upper data byte driven zero except on program data cycles, which carry all of r.data
  function automatic fcsl_pkg::fcsl_cyc_t cmd_cyc(input fcsl_pkg::fcsl_req_t r, input logic [2:0] i);
    logic [AW-1:0]       u1;
    logic [AW-1:0]       u2;
    fcsl_pkg::fcsl_cyc_t c;
    u1 = {r.addr[AW-1:LW], `FCSL_UNLOCK1};
    u2 = {r.addr[AW-1:LW], `FCSL_UNLOCK2};
    c  = (i[0] && i != 3'd3) ? wr(u2, `FCSL_CD_UNLOCK2) : wr(u1, `FCSL_CD_UNLOCK1);
    unique case (r.op)
      fcsl_pkg::FCSL_OP_READ:           c = '{write: 1'b0, addr: r.addr, data: '0};
      fcsl_pkg::FCSL_OP_RESET:          c = wr(r.addr, `FCSL_CD_RESET);
      fcsl_pkg::FCSL_OP_PROGRAM: begin
        if (i == 3'd2) c = wr(u1, `FCSL_CD_PROGRAM);
        if (i == 3'd3) c = '{write: 1'b1, addr: r.addr, data: r.data};
      end
      fcsl_pkg::FCSL_OP_BYPASS_ENTER: begin
        if (i == 3'd2) c = wr(u1, `FCSL_CD_BYPASS);
      end
      fcsl_pkg::FCSL_OP_BYPASS_PROGRAM: begin
        c = (i == 3'd0) ? wr(r.addr, `FCSL_CD_PROGRAM) : '{write: 1'b1, addr: r.addr, data: r.data};
      end
      fcsl_pkg::FCSL_OP_BYPASS_RESET: begin
        c = (i == 3'd0) ? wr(r.addr, `FCSL_CD_IDENT) : wr(r.addr, `FCSL_CD_BYP_EXIT);
      end
      fcsl_pkg::FCSL_OP_ERASE_CHIP, fcsl_pkg::FCSL_OP_ERASE_SECTOR: begin
        if (i == 3'd2) c = wr(u1, `FCSL_CD_ERASE);
        if (i == 3'd4) c = wr(u2, `FCSL_CD_UNLOCK2);
        if (i == 3'd5) begin
          c = (r.op == fcsl_pkg::FCSL_OP_ERASE_CHIP) ? wr(u1, `FCSL_CD_CHIP)
                                                     : wr(r.addr, `FCSL_CD_SECTOR);
        end
      end
      fcsl_pkg::FCSL_OP_SUSPEND:        c = wr(r.addr, `FCSL_CD_SUSPEND);
      fcsl_pkg::FCSL_OP_RESUME:         c = wr(r.addr, `FCSL_CD_RESUME);
      fcsl_pkg::FCSL_OP_ID_READ: begin
        if (i == 3'd2) c = wr(u1, `FCSL_CD_IDENT);
        if (i == 3'd3) c = '{write: 1'b0, addr: r.addr, data: '0};
      end
      fcsl_pkg::FCSL_OP_PARAM_QUERY:    c = wr({r.addr[AW-1:LW], `FCSL_QUERY_ADR}, `FCSL_CD_QUERY);
      default:                          c = wr(r.addr, `FCSL_CD_RESET);
    endcase
    return c;
  endfunction : cmd_cyc

  function automatic logic [2:0] cmd_len(input fcsl_pkg::fcsl_op_t op);
    unique case (op)
      fcsl_pkg::FCSL_OP_PROGRAM, fcsl_pkg::FCSL_OP_ID_READ:                 return 3'd4;
      fcsl_pkg::FCSL_OP_BYPASS_ENTER:                                       return 3'd3;
      fcsl_pkg::FCSL_OP_BYPASS_PROGRAM, fcsl_pkg::FCSL_OP_BYPASS_RESET:     return 3'd2;
      fcsl_pkg::FCSL_OP_ERASE_CHIP, fcsl_pkg::FCSL_OP_ERASE_SECTOR:         return 3'd6;
      default:                                                              return 3'd1;
    endcase
  endfunction : cmd_len

  fcsl_pkg::fcsl_state_t state_q;
  fcsl_pkg::fcsl_req_t   req_q;
  fcsl_pkg::fcsl_rsp_t   rsp_q;
  logic [2:0]            idx_q;
  logic                  go_q;
  logic [AW-1:0]         poll_addr_q;
  logic                  poll_erase_q;
  logic [DW-1:0]         v1_q;
  logic [DW-1:0]         v2_q;
  logic                  tl_seen_q;
  logic                  susp_pend_q;
  logic                  bypass_q;
  logic                  suspended_q;
  logic                  id_mode_q;
  logic                  rsp_valid_q;

  logic                  bus_done;
  logic [DW-1:0]         bus_rdata;
  logic                  bus_ready;
  fcsl_pkg::fcsl_cyc_t   bus_cyc;

  // Request screening in idle
  wire is_bypass_ok = (req_i.op == fcsl_pkg::FCSL_OP_READ) || (req_i.op == fcsl_pkg::FCSL_OP_RESET) ||
                      (req_i.op == fcsl_pkg::FCSL_OP_BYPASS_PROGRAM) || (req_i.op == fcsl_pkg::FCSL_OP_BYPASS_RESET);
  wire is_erase     = (req_i.op == fcsl_pkg::FCSL_OP_ERASE_CHIP) || (req_i.op == fcsl_pkg::FCSL_OP_ERASE_SECTOR);
  wire refuse       = (bypass_q && !is_bypass_ok) ||
                      (!bypass_q && (req_i.op == fcsl_pkg::FCSL_OP_BYPASS_PROGRAM)) ||
                      (req_i.op == fcsl_pkg::FCSL_OP_SUSPEND) ||
                      (suspended_q && is_erase) ||
                      (!suspended_q && (req_i.op == fcsl_pkg::FCSL_OP_RESUME)) ||
                      (suspended_q && !id_mode_q && (req_i.op == fcsl_pkg::FCSL_OP_PARAM_QUERY));
  wire in_idle      = (state_q == fcsl_pkg::FCSL_S_IDLE);
  // Suspend is only taken between status reads of a running erase
  wire accept_susp  = (state_q == fcsl_pkg::FCSL_S_DECIDE) && poll_erase_q && !susp_pend_q && req_valid_i &&
                      (req_i.op == fcsl_pkg::FCSL_OP_SUSPEND);
  wire take_new     = in_idle && req_valid_i;
  wire toggling     = v1_q[`FCSL_BIT_TOGGLE1] ^ v2_q[`FCSL_BIT_TOGGLE1];
  wire last_cmd     = (idx_q == cmd_len(req_q.op) - 3'd1);
  wire polls_op     = (req_q.op == fcsl_pkg::FCSL_OP_PROGRAM) || (req_q.op == fcsl_pkg::FCSL_OP_BYPASS_PROGRAM) ||
                      (req_q.op == fcsl_pkg::FCSL_OP_ERASE_CHIP) || (req_q.op == fcsl_pkg::FCSL_OP_ERASE_SECTOR) ||
                      (req_q.op == fcsl_pkg::FCSL_OP_SUSPEND) || (req_q.op == fcsl_pkg::FCSL_OP_RESUME);
  // Only a sector erase may be suspended, never a chip erase
  wire erase_op     = (req_q.op == fcsl_pkg::FCSL_OP_ERASE_SECTOR) || (req_q.op == fcsl_pkg::FCSL_OP_RESUME);
  wire launch_st    = (state_q == fcsl_pkg::FCSL_S_ISSUE) || (state_q == fcsl_pkg::FCSL_S_POLL1) ||
                      (state_q == fcsl_pkg::FCSL_S_POLL2) || (state_q == fcsl_pkg::FCSL_S_FINAL) ||
                      (state_q == fcsl_pkg::FCSL_S_RECOVER);
  wire bus_start    = launch_st && !go_q;
  wire fcsl_pkg::fcsl_cyc_t poll_cyc  = '{write: 1'b0, addr: poll_addr_q, data: '0};
  wire fcsl_pkg::fcsl_cyc_t reset_cyc = wr(poll_addr_q, `FCSL_CD_RESET);

  assign bus_cyc = (state_q == fcsl_pkg::FCSL_S_ISSUE)   ? cmd_cyc(req_q, idx_q) :
                   (state_q == fcsl_pkg::FCSL_S_RECOVER) ? reset_cyc : poll_cyc;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q      <= fcsl_pkg::FCSL_S_IDLE;
      req_q        <= '0;
      rsp_q        <= '0;
      idx_q        <= 3'd0;
      go_q         <= 1'b0;
      poll_addr_q  <= '0;
      poll_erase_q <= 1'b0;
      v1_q         <= '0;
      v2_q         <= '0;
      tl_seen_q    <= 1'b0;
      susp_pend_q  <= 1'b0;
      bypass_q     <= 1'b0;
      suspended_q  <= 1'b0;
      id_mode_q    <= 1'b0;
      rsp_valid_q  <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (bus_start) go_q <= 1'b1;
      if (bus_done) go_q <= 1'b0;
      unique case (state_q)
        fcsl_pkg::FCSL_S_IDLE: begin
          if (take_new) begin
            req_q <= req_i;
            idx_q <= 3'd0;
            rsp_q <= '{data: '0, refused: refuse, timed_out: 1'b0, suspended: suspended_q};
            state_q <= refuse ? fcsl_pkg::FCSL_S_RESP : fcsl_pkg::FCSL_S_ISSUE;
          end
        end
        fcsl_pkg::FCSL_S_ISSUE: begin
          if (bus_done) begin
            idx_q <= idx_q + 3'd1;
            if (last_cmd) begin
              rsp_q.data <= bus_rdata;
              tl_seen_q  <= 1'b0;
              if (req_q.op != fcsl_pkg::FCSL_OP_SUSPEND) begin
                poll_addr_q  <= req_q.addr;
                poll_erase_q <= erase_op;
              end
              if (req_q.op == fcsl_pkg::FCSL_OP_RESET) id_mode_q <= 1'b0;
              if (req_q.op == fcsl_pkg::FCSL_OP_ID_READ) id_mode_q <= 1'b1;
              if (req_q.op == fcsl_pkg::FCSL_OP_BYPASS_ENTER) bypass_q <= 1'b1;
              if (req_q.op == fcsl_pkg::FCSL_OP_BYPASS_RESET) bypass_q <= 1'b0;
              if (req_q.op == fcsl_pkg::FCSL_OP_RESUME) suspended_q <= 1'b0;
              state_q <= polls_op ? fcsl_pkg::FCSL_S_POLL1 : fcsl_pkg::FCSL_S_RESP;
            end
          end
        end
        fcsl_pkg::FCSL_S_POLL1: begin
          if (bus_done) begin
            v1_q    <= bus_rdata;
            state_q <= fcsl_pkg::FCSL_S_POLL2;
          end
        end
        fcsl_pkg::FCSL_S_POLL2: begin
          if (bus_done) begin
            v2_q    <= bus_rdata;
            state_q <= fcsl_pkg::FCSL_S_DECIDE;
          end
        end
        fcsl_pkg::FCSL_S_DECIDE: begin
          if (accept_susp) begin
            req_q       <= req_i;
            idx_q       <= 3'd0;
            susp_pend_q <= 1'b1;
            state_q     <= fcsl_pkg::FCSL_S_ISSUE;
          end else if (!toggling) begin
            if (susp_pend_q) suspended_q <= 1'b1;
            rsp_q.suspended <= susp_pend_q | suspended_q;
            susp_pend_q     <= 1'b0;
            state_q         <= fcsl_pkg::FCSL_S_FINAL;
          end else if (tl_seen_q) begin
            rsp_q.timed_out <= 1'b1;
            susp_pend_q     <= 1'b0;
            state_q         <= fcsl_pkg::FCSL_S_RECOVER;
          end else begin
            tl_seen_q <= v2_q[`FCSL_BIT_TLIMIT];
            state_q   <= fcsl_pkg::FCSL_S_POLL1;
          end
        end
        fcsl_pkg::FCSL_S_FINAL: begin
          if (bus_done) begin
            rsp_q.data <= bus_rdata;
            state_q    <= fcsl_pkg::FCSL_S_RESP;
          end
        end
        fcsl_pkg::FCSL_S_RECOVER: begin
          if (bus_done) begin
            id_mode_q <= 1'b0;
            state_q   <= fcsl_pkg::FCSL_S_RESP;
          end
        end
        fcsl_pkg::FCSL_S_RESP: begin
          rsp_valid_q <= 1'b1;
          state_q     <= fcsl_pkg::FCSL_S_IDLE;
        end
        default: state_q <= fcsl_pkg::FCSL_S_IDLE;
      endcase
    end
  end

  // Strobe framing and pin synchronisers
  fcsl_bus_cycle #(
    .AW (AW),
    .DW (DW)
  ) u_bus (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .start_i        (bus_start),
    .cyc_i          (bus_cyc),
    .done_o         (bus_done),
    .rdata_o        (bus_rdata),
    .ready_o        (bus_ready),
    .addr_o         (flash_addr_o),
    .dq_o           (flash_dq_o),
    .dq_oe_o        (flash_dq_oe_o),
    .dq_i           (flash_dq_i),
    .ce_n_o         (flash_ce_n_o),
    .oe_n_o         (flash_oe_n_o),
    .we_n_o         (flash_we_n_o),
    .ready_busy_n_i (ready_busy_n_i)
  );

  assign req_ready_o   = in_idle || accept_susp;
  assign rsp_valid_o   = rsp_valid_q;
  assign rsp_o         = rsp_q;
  assign bypass_o      = bypass_q;
  assign suspended_o   = suspended_q;
  assign id_mode_o     = id_mode_q;
  assign flash_ready_o = bus_ready;

endmodule : fcsl_host

// ### verification/fcsl_host_props.sv
// Pin and response checker for the flash host controller
`timescale 1ns/100ps
module fcsl_host_props (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // User side
  input  wire logic          req_valid_i,
  input  wire logic          req_ready_o,
  input  fcsl_pkg::fcsl_req_t req_i,
  input  wire logic          rsp_valid_o,
  input  fcsl_pkg::fcsl_rsp_t rsp_o,
  input  wire logic          bypass_o,
  input  wire logic          suspended_o,
  input  wire logic          flash_ready_o,
  // Flash side
  input  wire logic [20:0]   flash_addr_o,
  input  wire logic [15:0]   flash_dq_o,
  input  wire logic          flash_dq_oe_o,
  input  wire logic          flash_ce_n_o,
  input  wire logic          flash_oe_n_o,
  input  wire logic          flash_we_n_o,
  input  wire logic          ready_busy_n_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire       take = req_valid_i && req_ready_o;
  wire [3:0] op   = req_i.op;
  chk_write_drive: assert property (!flash_we_n_o |-> flash_dq_oe_o && flash_oe_n_o && !flash_ce_n_o)
    else $error("write strobe without data drive");
  chk_read_release: assert property (!flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o && !flash_ce_n_o)
    else $error("read strobe while driving data");
  chk_addr_hold: assert property ($fell(flash_we_n_o) |=> !flash_we_n_o && $stable(flash_addr_o))
    else $error("address moved inside write pulse");
  chk_datum_hold: assert property ($rose(flash_we_n_o) |-> !flash_ce_n_o && flash_dq_oe_o && $stable(flash_dq_o))
    else $error("datum not held at write end");
  chk_ready_high: assert property (ready_busy_n_i [*8] |-> flash_ready_o)
    else $error("ready view stuck busy");
  chk_ready_low: assert property (!ready_busy_n_i [*8] |-> !flash_ready_o)
    else $error("ready view missed busy");
  chk_bypass_gate: assert property (take && op == fcsl_pkg::FCSL_OP_BYPASS_PROGRAM && !bypass_o
    |=> flash_ce_n_o ##[0:1] (rsp_valid_o && rsp_o.refused)) else $error("bypass program not refused");
  chk_erase_gate: assert property (take && op == fcsl_pkg::FCSL_OP_ERASE_SECTOR && suspended_o
    |=> flash_ce_n_o ##[0:1] (rsp_valid_o && rsp_o.refused)) else $error("erase in suspend not refused");
  chk_resume_gate: assert property (take && op == fcsl_pkg::FCSL_OP_RESUME && !suspended_o
    |=> flash_ce_n_o ##[0:1] (rsp_valid_o && rsp_o.refused)) else $error("stray resume not refused");
endmodule : fcsl_host_props
bind fcsl_host fcsl_host_props i_fcsl_host_props (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_i,
  .rsp_valid_o, .rsp_o, .bypass_o, .suspended_o, .flash_ready_o, .flash_addr_o, .flash_dq_o,
  .flash_dq_oe_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .ready_busy_n_i);

// ### verification/fcsl_flash_model.sv
// Behavioural parallel flash device facing the host controller
`timescale 1ns/100ps
module fcsl_flash_model #(
  parameter int          BUSY_RD = 6,
  parameter logic [8:0]  PROT    = 9'h010,
  parameter bit          LOCKED  = 1,
  parameter logic [15:0] DEV_ID  = 16'h005A  // Arbitrary value
) (
  // Host pins
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  // Device outputs
  output logic      [15:0] dq_o,
  output logic             busy_o
);
  logic [15:0] m[logic [20:0]];
  logic [20:0] al;
  logic [15:0] pd;
  logic [8:0]  sa;
  logic [1:0]  bb;
  logic        id = 0, byp = 0, er = 0, sus = 0, pr = 0, t6 = 0, t2 = 0, tl = 0;
  int          st = 0, bz = 0;
  wire  [7:0]  d = dq_i[7:0];
  initial dq_o = 16'h0000;
  assign busy_o = bz > 0 && !sus;
  // Strobes and address switch in one step; let them settle first
  always @(negedge we_n_i) #1 al = addr_i;
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (st == 4) begin
      tl = |(dq_i & ~(m.exists(al) ? m[al] : 16'hFFFF));
      if (al[20:12] != PROT && !tl) m[al] = (m.exists(al) ? m[al] : 16'hFFFF) & dq_i;
      pd = dq_i;
      pr = 1;
      bz = BUSY_RD;
      bb = al[20:19];
      st = 0;
    end else if (st == 6) begin
      byp = 0;
      st = 0;
    end else if (d == 8'hF0) begin
      st = 0;
      id = 0;
      if (tl) bz = 0;
      tl = 0;
    end else if (byp) st = d == 8'hA0 ? 4 : d == 8'h90 ? 6 : 0;
    else if (d == 8'hB0) sus = bz > 0 && !pr;
    else if (d == 8'h30 && sus && st == 0) sus = 0;
    else if (st < 2) st = d == (st ? 8'h55 : 8'hAA) && al[10:0] == (st ? 11'h2AA : 11'h555) ? st + 1 : 0;
    else begin
      st = d == 8'hA0 ? 4 : 0;
      id |= d == 8'h90;
      byp |= d == 8'h20;
      if (er && (d == 8'h10 || d == 8'h30)) begin
        pr = 0;
        bz = BUSY_RD;
        sa = al[20:12];
        bb = al[20:19];
      end
      er = d == 8'h80;
    end
  end
  // Released bus shows the inverse so a stale value is never mistaken for data
  always @(posedge oe_n_i) dq_o = ~dq_o;
  always @(negedge oe_n_i) #1 if (!ce_n_i) begin
    dq_o = m.exists(addr_i) ? m[addr_i] : 16'hFFFF;
    if (id) dq_o = addr_i[7:0] == 8'h02 ? {15'h0000, addr_i[20:12] == PROT} :
      addr_i[7:0] == 8'h03 ? {8'h00, LOCKED, 7'h01} : DEV_ID;
    else if (bz > 0 && addr_i[20:19] == bb) begin
      t6 ^= !sus;
      t2 ^= !pr && addr_i[20:12] == sa;
      dq_o = {8'h00, pr ? ~pd[7] : sus, t6, tl, 2'h0, t2, 2'h0};
      if (!sus && !tl) bz--;
      // Erase clears the whole array; scenarios erase one sector only
      if (bz == 0 && !pr && sa != PROT) m.delete();
    end
  end
endmodule : fcsl_flash_model

// ### verification/test_fcsl_host.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
module test_fcsl_host;
  logic                clk_i = 0, rst_i = 1, req_valid_i = 0, rb_low, fr;
  logic                rsp_valid_o, req_ready_o, bypass_o, suspended_o, id_mode_o, ce_n, oe_n, we_n, dq_oe;
  fcsl_pkg::fcsl_req_t req_i = '0;
  fcsl_pkg::fcsl_rsp_t rsp_o;
  logic [20:0]         fa;
  logic [15:0]         fdo, fdi;
  int                  fails = 0, checks_done = 0, n;
  fcsl_host i_fcsl_host (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_i, .rsp_valid_o, .rsp_o,
    .bypass_o, .suspended_o, .id_mode_o, .flash_ready_o(fr), .flash_addr_o(fa), .flash_dq_o(fdo),
    .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_oe ? fdo : fdi), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n), .ready_busy_n_i(!rb_low));
  fcsl_flash_model i_fcsl_flash_model (.addr_i(fa), .dq_i(fdo), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .dq_o(fdi), .busy_o(rb_low));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic put(input fcsl_pkg::fcsl_op_t o, input logic [20:0] a, input logic [15:0] d = 16'h0000);
    @(negedge clk_i);
    req_i = {o, a, d};
    req_valid_i = 1;
    for (n = 0; req_ready_o !== 1 && n < 4000; n++) @(negedge clk_i);
    if (n >= 4000) fails++;
    @(negedge clk_i);
    req_valid_i = 0;
  endtask : put
  task automatic get;
    for (n = 0; rsp_valid_o !== 1 && n < 4000; n++) @(negedge clk_i);
    if (n >= 4000) fails++;
  endtask : get
  task automatic op(input fcsl_pkg::fcsl_op_t o, input logic [20:0] a, input logic [15:0] d = 16'h0000);
    put(o, a, d);
    get;
  endtask : op
  task automatic t_program;
    put(fcsl_pkg::FCSL_OP_PROGRAM, 21'h00_1234, 16'h1234);
    repeat (40) @(negedge clk_i);
    chk("busy pin view", fr, 0);
    get;
    chk("program result", rsp_o.data, 16'h1234);
    chk("ready pin view", fr, 1);
    op(fcsl_pkg::FCSL_OP_READ, 21'h00_1234);
    chk("array read", rsp_o.data, 16'h1234);
    op(fcsl_pkg::FCSL_OP_PROGRAM, 21'h00_1234, 16'hFFFF);
    chk("timing limit", rsp_o.timed_out, 1);
    op(fcsl_pkg::FCSL_OP_PROGRAM, 21'h01_0040, 16'h0000);
    op(fcsl_pkg::FCSL_OP_READ, 21'h01_0040);
    chk("protected word", rsp_o.data, 16'hFFFF);
  endtask : t_program
  task automatic t_bypass;
    op(fcsl_pkg::FCSL_OP_BYPASS_PROGRAM, 21'h02_0010, 16'hA5A5);
    chk("bypass gate", rsp_o.refused, 1);
    op(fcsl_pkg::FCSL_OP_BYPASS_ENTER, 0);
    op(fcsl_pkg::FCSL_OP_BYPASS_PROGRAM, 21'h02_0010, 16'hA5A5);
    op(fcsl_pkg::FCSL_OP_READ, 21'h02_0010);
    chk("bypass data", rsp_o.data, 16'hA5A5);
    op(fcsl_pkg::FCSL_OP_BYPASS_RESET, 21'h02_0010);
    chk("bypass exit", bypass_o, 0);
  endtask : t_bypass
  task automatic t_ident;
    op(fcsl_pkg::FCSL_OP_ID_READ, 21'h01_0002);
    chk("protect verify", rsp_o.data, 16'h0001);
    op(fcsl_pkg::FCSL_OP_READ, 21'h01_0003);
    chk("lock query", rsp_o.data, 16'h0081);
    chk("query mode", id_mode_o, 1);
    op(fcsl_pkg::FCSL_OP_RESET, 0);
    chk("query exit", id_mode_o, 0);
  endtask : t_ident
  task automatic t_erase;
    put(fcsl_pkg::FCSL_OP_ERASE_SECTOR, 21'h00_1234);
    put(fcsl_pkg::FCSL_OP_SUSPEND, 21'h00_1234);
    get;
    chk("erase suspended", rsp_o.suspended, 1);
    chk("suspend flag", suspended_o, 1);
    chk("ready in suspend", fr, 1);
    op(fcsl_pkg::FCSL_OP_PARAM_QUERY, 21'h00_1234);
    chk("query in suspend", rsp_o.refused, 1);
    op(fcsl_pkg::FCSL_OP_ERASE_SECTOR, 21'h00_1234);
    chk("erase in suspend", rsp_o.refused, 1);
    op(fcsl_pkg::FCSL_OP_RESUME, 21'h00_1234);
    op(fcsl_pkg::FCSL_OP_READ, 21'h00_1234);
    chk("erased word", rsp_o.data, 16'hFFFF);
    op(fcsl_pkg::FCSL_OP_RESUME, 21'h00_1234);
    chk("resume gate", rsp_o.refused, 1);
  endtask : t_erase
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    #2_000_000;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 0;
    t_program;
    t_bypass;
    t_ident;
    t_erase;
    tally_and_finish;
  end
endmodule : test_fcsl_host
